// ===== core/crtc_consts.svh
// constants for the display timing register set
// assumes inclusion by the package and the core module only
`ifndef CRTC_CONSTS_SVH
`define CRTC_CONSTS_SVH
`define CRTC_IDX_HTOTAL 5'h00
`define CRTC_IDX_HDISP 5'h01
`define CRTC_IDX_HSPOS 5'h02
`define CRTC_IDX_SYNCW 5'h03
`define CRTC_IDX_VTOTAL 5'h04
`define CRTC_IDX_VADJ 5'h05
`define CRTC_IDX_VDISP 5'h06
`define CRTC_IDX_VSPOS 5'h07
`define CRTC_IDX_MODE 5'h08
`define CRTC_IDX_MAXSCAN 5'h09
`define CRTC_IDX_CURSTART 5'h0a
`define CRTC_IDX_CUREND 5'h0b
`define CRTC_IDX_STARTH 5'h0c
`define CRTC_IDX_STARTL 5'h0d
`define CRTC_IDX_CURH 5'h0e
`define CRTC_IDX_CURL 5'h0f
`define CRTC_IDX_PENH 5'h10
`define CRTC_IDX_PENL 5'h11
`define CRTC_IDX_SPSTART 5'h12
`define CRTC_IDX_SPEND 5'h13
`define CRTC_IDX_WSTART 5'h14
`define CRTC_IDX_WEND 5'h15
`define CRTC_IDX_LAST 5'h17
`define CRTC_MODE_INTERLACE 1
`define CRTC_MODE_VIDEO 0
`define CRTC_MODE_WSKEW_HI 5
`define CRTC_MODE_WSKEW_LO 4
`define CRTC_MODE_CSKEW_HI 7
`define CRTC_MODE_CSKEW_LO 6
`define CRTC_CUR_PANEL 7
`define CRTC_CUR_BLINK 6
`define CRTC_CUR_RATE 5
`define CRTC_SP_PANELS 7
`define CRTC_BLINK_FAST 5'h0f
`define CRTC_BLINK_SLOW 5'h1f
`define CRTC_VSYNC_FULL 5'h10
`endif

// ===== core/crtc_pkg.sv
// types shared by the display timing register set
// assumes crtc_consts.svh sits beside it
`include "crtc_consts.svh"
package crtc_pkg;
  typedef enum logic [1:0] {crtc_cur_steady, crtc_cur_off, crtc_cur_blink16, crtc_cur_blink32} crtc_cur_mode_t;
  typedef logic [7:0] crtc_byte_t;
  typedef logic [15:0] crtc_addr_t;
endpackage : crtc_pkg

// ===== core/crtc_timing.sv
// raster timing generator with host-indexed register set
// assumes synchronous host bus sampled on clk, one char time per clk
// What this block does
// - outside lcd mode, mode bits select non-interlace or interlace modes
// - window skew delays display flag zero-two chars
// - cursor skew delays cursor output zero-two chars
// - cursor steady, hidden, blink sixteen or thirtytwo
// - panel select bit puts cursor on lower
// - panel count bit picks one or two
// - shift pulse start field is the first column itself
// - write index first, then access selected register
// - syncs start at programmed place plus one
// - sync widths, vertical zero means sixteen
// - extra scan lines lengthen the frame
// - refresh starts from the start address pair
// - cursor where refresh address equals cursor address
// - pen strobe rising edge captures refresh address
// - window and shift pulse gated by column positions
`timescale 1ns/1ps
`include "crtc_consts.svh"
module crtc_timing (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host bus
  input wire logic chip_select_n,
  input wire logic reg_select,
  input wire logic read_not_write,
  input wire logic access_strobe,
  input wire crtc_pkg::crtc_byte_t write_data,
  output crtc_pkg::crtc_byte_t read_data,
  output logic read_data_oe,
  // mode and pen
  input wire logic lcd_mode,
  input wire logic pen_capture_strobe,
  // display outputs
  output crtc_pkg::crtc_addr_t refresh_addr,
  output logic [4:0] line_addr,
  output logic hsync,
  output logic vsync,
  output logic active_display_flag,
  output logic cursor_window_out,
  output logic column_shift_pulse,
  output logic lower_panel,
  output logic two_panel_mode
);
  import crtc_pkg::*;

  // ==========================================================
  // register file
  logic [4:0] register_index, next_register_index;
  crtc_byte_t regs [0:21];
  crtc_byte_t next_regs [0:21];
  crtc_addr_t pen_capture, next_pen_capture;
  logic pen_prev, next_pen_prev;
  logic bus_write, bus_read;

  function automatic logic idx_readable(input logic [4:0] i);
    idx_readable = (i >= `CRTC_IDX_STARTH) && (i <= `CRTC_IDX_WEND);
  endfunction : idx_readable

  assign bus_write = access_strobe && !chip_select_n && !read_not_write;
  assign bus_read = access_strobe && !chip_select_n && read_not_write && reg_select;

  always_comb
  begin
    next_register_index = register_index;
    for (int i = 0; i < 22; i++)
    begin
      next_regs[i] = regs[i];
    end
    next_pen_prev = pen_capture_strobe;
    next_pen_capture = pen_capture;
    if (pen_capture_strobe && !pen_prev)
    begin
      next_pen_capture = refresh_addr;
    end
    if (bus_write && !reg_select)
    begin
      next_register_index = write_data[4:0];
    end
    else if (bus_write && register_index <= `CRTC_IDX_WEND && register_index != `CRTC_IDX_PENH
             && register_index != `CRTC_IDX_PENL)
    begin
      next_regs[register_index] = write_data;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      register_index <= 5'h00;
      for (int i = 0; i < 22; i++)
      begin
        regs[i] <= 8'h00;
      end
      pen_capture <= 16'h0000;
      pen_prev <= 1'b0;
    end
    else
    begin
      register_index <= next_register_index;
      for (int i = 0; i < 22; i++)
      begin
        regs[i] <= next_regs[i];
      end
      pen_capture <= next_pen_capture;
      pen_prev <= next_pen_prev;
    end
  end

  // read path: registered data, zero for write-only or unused slots
  crtc_byte_t next_read_data;
  always_comb
  begin
    next_read_data = 8'h00;
    if (bus_read && idx_readable(register_index))
    begin
      if (register_index == `CRTC_IDX_PENH)
      begin
        next_read_data = pen_capture[15:8];
      end
      else if (register_index == `CRTC_IDX_PENL)
      begin
        next_read_data = pen_capture[7:0];
      end
      else
      begin
        next_read_data = regs[register_index];
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      read_data <= 8'h00;
    end
    else
    begin
      read_data <= next_read_data;
    end
  end
  assign read_data_oe = access_strobe && !chip_select_n && read_not_write;

  // ==========================================================
  // field decode
  logic [1:0] wskew, cskew;
  logic interlace, int_video, panel_sel, two_panel;
  logic [4:0] max_line, cur_first, cur_last, vadj;
  logic [4:0] vsync_lines;
  logic [3:0] hsync_chars;
  crtc_cur_mode_t cur_mode;
  assign interlace = !lcd_mode && regs[`CRTC_IDX_MODE][`CRTC_MODE_INTERLACE];
  assign int_video = interlace && regs[`CRTC_IDX_MODE][`CRTC_MODE_VIDEO];
  assign wskew = {regs[`CRTC_IDX_MODE][`CRTC_MODE_WSKEW_HI], regs[`CRTC_IDX_MODE][`CRTC_MODE_WSKEW_LO]};
  assign cskew = {regs[`CRTC_IDX_MODE][`CRTC_MODE_CSKEW_HI], regs[`CRTC_IDX_MODE][`CRTC_MODE_CSKEW_LO]};
  assign cur_mode = crtc_cur_mode_t'({regs[`CRTC_IDX_CURSTART][`CRTC_CUR_BLINK],
                                      regs[`CRTC_IDX_CURSTART][`CRTC_CUR_RATE]});
  assign cur_first = regs[`CRTC_IDX_CURSTART][4:0];
  assign cur_last = regs[`CRTC_IDX_CUREND][4:0];
  assign panel_sel = regs[`CRTC_IDX_CURSTART][`CRTC_CUR_PANEL];
  assign two_panel = regs[`CRTC_IDX_SPSTART][`CRTC_SP_PANELS];
  assign max_line = regs[`CRTC_IDX_MAXSCAN][4:0];
  assign vadj = regs[`CRTC_IDX_VADJ][4:0];
  assign hsync_chars = regs[`CRTC_IDX_SYNCW][3:0];
  assign vsync_lines = (regs[`CRTC_IDX_SYNCW][7:4] == 4'h0) ? `CRTC_VSYNC_FULL
                       : {1'b0, regs[`CRTC_IDX_SYNCW][7:4]};
  assign two_panel_mode = lcd_mode && two_panel;

  // ==========================================================
  // counters
  logic [7:0] hcount, next_hcount, row, next_row;
  logic [4:0] line, next_line, hs_cnt, next_hs_cnt, vs_cnt, next_vs_cnt;
  logic in_adj, next_in_adj, field, next_field;
  logic [4:0] frames, next_frames;
  crtc_addr_t row_base, next_row_base, addr, next_addr;
  logic line_end, row_end, frame_end;
  logic [4:0] row_last_line;

  // interlace sync and video steps two lines per scan
  assign row_last_line = in_adj ? vadj - 5'h01 : max_line;
  assign line_end = (hcount == regs[`CRTC_IDX_HTOTAL]);
  assign row_end = line_end && (int_video ? (line >= row_last_line - 5'h01) : (line == row_last_line));
  assign frame_end = row_end && (in_adj || (row == regs[`CRTC_IDX_VTOTAL] && vadj == 5'h00));

  always_comb
  begin
    next_hcount = line_end ? 8'h00 : hcount + 8'h01;
    next_line = line;
    next_row = row;
    next_in_adj = in_adj;
    next_field = field;
    next_frames = frames;
    next_row_base = row_base;
    next_addr = addr + 16'h0001;
    next_hs_cnt = (hs_cnt != 5'h00) ? hs_cnt - 5'h01 : 5'h00;
    next_vs_cnt = vs_cnt;
    if (hcount == regs[`CRTC_IDX_HSPOS] && hsync_chars != 4'h0)
    begin
      next_hs_cnt = {1'b0, hsync_chars};
    end
    if (line_end)
    begin
      next_addr = row_base;
      next_line = int_video ? line + 5'h02 : line + 5'h01;
      if (vs_cnt != 5'h00)
      begin
        next_vs_cnt = vs_cnt - 5'h01;
      end
      if (line == 5'h00 && !in_adj && row == regs[`CRTC_IDX_VSPOS])
      begin
        next_vs_cnt = vsync_lines;
      end
      if (row_end)
      begin
        next_line = (int_video && field) ? 5'h01 : 5'h00;
        next_row = row + 8'h01;
        next_row_base = row_base + {8'h00, regs[`CRTC_IDX_HDISP]};
        next_addr = next_row_base;
        if (!in_adj && row == regs[`CRTC_IDX_VTOTAL] && vadj != 5'h00)
        begin
          next_in_adj = 1'b1;
        end
      end
      if (frame_end)
      begin
        next_row = 8'h00;
        next_in_adj = 1'b0;
        next_field = interlace ? !field : 1'b0;
        next_line = (int_video && !field) ? 5'h01 : 5'h00;
        next_frames = frames + 5'h01;
        next_row_base = {regs[`CRTC_IDX_STARTH], regs[`CRTC_IDX_STARTL]};
        next_addr = next_row_base;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hcount <= 8'h00;
      line <= 5'h00;
      row <= 8'h00;
      in_adj <= 1'b0;
      field <= 1'b0;
      frames <= 5'h00;
      row_base <= 16'h0000;
      addr <= 16'h0000;
      hs_cnt <= 5'h00;
      vs_cnt <= 5'h00;
    end
    else
    begin
      hcount <= next_hcount;
      line <= next_line;
      row <= next_row;
      in_adj <= next_in_adj;
      field <= next_field;
      frames <= next_frames;
      row_base <= next_row_base;
      addr <= next_addr;
      hs_cnt <= next_hs_cnt;
      vs_cnt <= next_vs_cnt;
    end
  end

  // ==========================================================
  // window, cursor and skew
  logic disp_raw, cur_raw, blink_on, cur_line_ok, sp_raw;
  logic [1:0] disp_dly, cur_dly;
  logic next_active, next_cursor;
  assign disp_raw = (hcount >= regs[`CRTC_IDX_WSTART]) && (hcount <= regs[`CRTC_IDX_WEND])
                    && (hcount < regs[`CRTC_IDX_HDISP]) && !in_adj
                    && (row < regs[`CRTC_IDX_VDISP]);
  assign sp_raw = (hcount >= {1'b0, regs[`CRTC_IDX_SPSTART][6:0]})
                  && (hcount <= regs[`CRTC_IDX_SPEND]) && !in_adj;
  always_comb
  begin
    unique case (cur_mode)
      crtc_cur_steady: blink_on = 1'b1;
      crtc_cur_off: blink_on = 1'b0;
      crtc_cur_blink16: blink_on = ((frames & `CRTC_BLINK_FAST) < 5'h08);
      crtc_cur_blink32: blink_on = ((frames & `CRTC_BLINK_SLOW) < 5'h10);
    endcase
  end
  assign cur_line_ok = (line >= cur_first) && (line <= cur_last);
  assign cur_raw = disp_raw && blink_on && cur_line_ok
                   && (addr == {regs[`CRTC_IDX_CURH], regs[`CRTC_IDX_CURL]});

  always_comb
  begin
    unique case (wskew)
      2'b01: next_active = disp_dly[0];
      2'b10: next_active = disp_dly[1];
      default: next_active = disp_raw;
    endcase
    unique case (cskew)
      2'b01: next_cursor = cur_dly[0];
      2'b10: next_cursor = cur_dly[1];
      default: next_cursor = cur_raw;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      disp_dly <= 2'b00;
      cur_dly <= 2'b00;
      active_display_flag <= 1'b0;
      cursor_window_out <= 1'b0;
      column_shift_pulse <= 1'b0;
      hsync <= 1'b0;
      vsync <= 1'b0;
      refresh_addr <= 16'h0000;
      line_addr <= 5'h00;
      lower_panel <= 1'b0;
    end
    else
    begin
      disp_dly <= {disp_dly[0], disp_raw};
      cur_dly <= {cur_dly[0], cur_raw};
      active_display_flag <= next_active;
      cursor_window_out <= next_cursor;
      column_shift_pulse <= lcd_mode && sp_raw;
      hsync <= (hs_cnt != 5'h00);
      vsync <= (vs_cnt != 5'h00);
      refresh_addr <= addr;
      line_addr <= line;
      lower_panel <= two_panel_mode && panel_sel;
    end
  end

  // ==========================================================
  // checks
  a_index_write: assert property (@(posedge clk) disable iff (reset)
    (bus_write && !reg_select) |=> (register_index == $past(write_data[4:0])))
    else $error("index not loaded");
  a_wo_reads_zero: assert property (@(posedge clk) disable iff (reset)
    (bus_read && !idx_readable(register_index)) |=> (read_data == 8'h00))
    else $error("write-only read not zero");
  a_pen_capture: assert property (@(posedge clk) disable iff (reset)
    (pen_capture_strobe && !pen_prev) |=> (pen_capture == $past(refresh_addr)))
    else $error("pen capture missed");
  a_no_skew: assert property (@(posedge clk) disable iff (reset)
    (wskew == 2'b00) |=> (active_display_flag == $past(disp_raw)))
    else $error("display flag skew wrong");
  a_cursor_skew: assert property (@(posedge clk) disable iff (reset)
    (cskew == 2'b10 && $stable(cskew)) |=> (cursor_window_out == $past(cur_raw, 3)))
    else $error("cursor skew wrong");
  a_cursor_hidden: assert property (@(posedge clk) disable iff (reset)
    (cur_mode == crtc_cur_off) |-> !cur_raw)
    else $error("hidden cursor shown");
  a_cursor_lines: assert property (@(posedge clk) disable iff (reset)
    cur_raw |-> (line >= cur_first && line <= cur_last))
    else $error("cursor outside lines");
  a_hsync_start: assert property (@(posedge clk) disable iff (reset)
    (hcount == regs[`CRTC_IDX_HSPOS] && hsync_chars == 4'h1) |=> ##1 hsync ##1 !hsync)
    else $error("hsync width one wrong");
  a_frame_start: assert property (@(posedge clk) disable iff (reset)
    frame_end |=> (addr == $past({regs[`CRTC_IDX_STARTH], regs[`CRTC_IDX_STARTL]})))
    else $error("frame start address wrong");
  a_lcd_noninterlace: assert property (@(posedge clk) disable iff (reset)
    lcd_mode |-> !interlace)
    else $error("interlace in lcd mode");
endmodule : crtc_timing

// ===== dv/crtc_host.sv
// host processor model driving the register bus of the timing block
// assumes the bench calls access() once per bus cycle, clk is the bus clock
`timescale 1ns/1ps
module crtc_host (
  // clock
  input wire logic clk,
  // bus toward the device
  output logic chip_select_n,
  output logic reg_select,
  output logic read_not_write,
  output logic access_strobe,
  output crtc_pkg::crtc_byte_t write_data
);
  import crtc_pkg::*;
  // ==========================================
  // bus cycles
  initial
  begin
    chip_select_n = 1'b1;
    reg_select = 1'b0;
    read_not_write = 1'b1;
    access_strobe = 1'b0;
    write_data = 8'h00;
  end
  // a register number goes in at select 0 before any data access at select 1
  task automatic access(input logic rs, input logic rnw, input crtc_byte_t data);
    @(negedge clk);
    chip_select_n = 1'b0;
    reg_select = rs;
    read_not_write = rnw;
    write_data = data;
    access_strobe = 1'b1;
    @(negedge clk);
    chip_select_n = 1'b1;
    access_strobe = 1'b0;
    // released bus shows inverted data and select, so stale data cannot look right
    write_data = ~data;
    reg_select = ~rs;
  endtask : access
endmodule : crtc_host

// ===== dv/crtc_lcd_timing_register_set_bench.sv
// self-checking bench for the display timing register set
// assumes crtc_host as the bus partner and one character time per clk
`timescale 1ns/1ps
module crtc_lcd_timing_register_set_bench;
  import crtc_pkg::*;
  logic clk, reset, chip_select_n, reg_select, read_not_write, access_strobe, lcd_mode, pen_capture_strobe;
  crtc_byte_t write_data, read_data;
  crtc_addr_t refresh_addr;
  logic [4:0] line_addr;
  logic read_data_oe, hsync, vsync, active_display_flag, cursor_window_out;
  logic column_shift_pulse, lower_panel, two_panel_mode;
  int mismatches = 0;
  int n_checks = 0;
  crtc_byte_t expq[$];
  crtc_byte_t saved[8];
  logic took = 1'b0;
  logic [31:0] seed = 32'h608da05e;
  logic [4:0] rw_idx[8] = '{5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h14, 5'h15};
  logic [3:0] widths[3] = '{4'h1, 4'h7, 4'hf};
  // ==========================================
  // clock, partner and device
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  crtc_host host (.clk(clk), .chip_select_n(chip_select_n), .reg_select(reg_select),
    .read_not_write(read_not_write), .access_strobe(access_strobe), .write_data(write_data));
  crtc_timing dut (.clk(clk), .reset(reset), .chip_select_n(chip_select_n), .reg_select(reg_select),
    .read_not_write(read_not_write), .access_strobe(access_strobe), .write_data(write_data),
    .read_data(read_data), .read_data_oe(read_data_oe), .lcd_mode(lcd_mode),
    .pen_capture_strobe(pen_capture_strobe), .refresh_addr(refresh_addr), .line_addr(line_addr),
    .hsync(hsync), .vsync(vsync), .active_display_flag(active_display_flag),
    .cursor_window_out(cursor_window_out), .column_shift_pulse(column_shift_pulse),
    .lower_panel(lower_panel), .two_panel_mode(two_panel_mode));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [4:0] idx, input crtc_byte_t d);
    host.access(1'b0, 1'b0, {3'h0, idx});
    host.access(1'b1, 1'b0, d);
  endtask : wr
  task automatic rd(input logic [4:0] idx, input crtc_byte_t exp);
    expq.push_back(exp);
    host.access(1'b0, 1'b0, {3'h0, idx});
    host.access(1'b1, 1'b1, 8'h00);
  endtask : rd
  task automatic wait_hs(input logic v, output int n);
    n = 0;
    while (hsync !== v && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
    begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_hs
  // sums over 320 clocks, exactly one frame of 4 rows, 2 lines, 40 chars
  task automatic count_frame(output int act_n, output int sp_n, output int vs_n, output int cur_n);
    act_n = 0;
    sp_n = 0;
    vs_n = 0;
    cur_n = 0;
    repeat (320)
    begin
      @(negedge clk);
      if (active_display_flag === 1'b1)
        act_n++;
      if (column_shift_pulse === 1'b1)
        sp_n++;
      if (vsync === 1'b1)
        vs_n++;
      if (cursor_window_out === 1'b1)
        cur_n++;
    end
  endtask : count_frame
  // ==========================================
  // read watcher: data stands for the one cycle after the strobe edge, then drops to zero
  always @(posedge clk)
  begin
    took <= access_strobe & ~chip_select_n & read_not_write & reg_select;
  end
  always @(negedge clk)
  begin
    if (took === 1'b1 && expq.size() == 0)
      check("unexpected read", 16'h0001, 16'h0000);
    else if (took === 1'b1)
      check("read_data", {8'h00, read_data}, {8'h00, expq.pop_front()});
    else
      check("idle read_data", {8'h00, read_data}, 16'h0000);
  end
  // ==========================================
  // main sequence
  initial
  begin
    int hi, lo, n, act_n, sp_n, vs_n, cur_n;
    crtc_addr_t pen_seen;
    reset = 1'b1;
    lcd_mode = 1'b0;
    pen_capture_strobe = 1'b0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 8; i++)
      rd(rw_idx[i], 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      saved[i] = seed[7:0];
      wr(rw_idx[i], saved[i]);
    end
    for (int i = 0; i < 8; i++)
      rd(rw_idx[i], saved[i]);
    // write-only and unmapped places read zero, and the read-only pen place reads zero before any capture
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      wr(i[4:0], seed[7:0] | 8'h01);
      rd(i[4:0], 8'h00);
    end
    wr(5'h10, 8'ha5);
    rd(5'h10, 8'h00);
    for (int i = 22; i < 32; i++)
      rd(i[4:0], 8'h00);
    lcd_mode = 1'b1;
    wr(5'h12, 8'h80);
    check("two_panel_mode", {15'h0, two_panel_mode}, 16'h0001);
    rd(5'h12, 8'h80);
    wr(5'h0a, 8'h80);
    repeat (2) @(negedge clk);
    check("lower_panel", {15'h0, lower_panel}, 16'h0001);
    lcd_mode = 1'b0;
    repeat (2) @(negedge clk);
    check("two_panel_mode off", {15'h0, two_panel_mode}, 16'h0000);
    check("lower_panel off", {15'h0, lower_panel}, 16'h0000);
    // a reset in mid-run clears the random settings so the counters start from a known frame
    @(negedge clk);
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    rd(5'h0c, 8'h00);
    // a 40-character line, 16 shown, 4 rows of 2 lines, sync pulse at several widths
    wr(5'h00, 8'h27);
    wr(5'h01, 8'h20);
    wr(5'h02, 8'h05);
    wr(5'h09, 8'h01);
    wr(5'h04, 8'h03);
    wr(5'h05, 8'h00);
    wr(5'h06, 8'h02);
    wr(5'h08, 8'h90);
    wr(5'h14, 8'h04);
    wr(5'h15, 8'h13);
    wr(5'h0b, 8'h01);
    wr(5'h0e, 8'h00);
    wr(5'h0f, 8'h25);
    for (int i = 0; i < 3; i++)
    begin
      wr(5'h03, {4'h1, widths[i]});
      wait_hs(1'b0, n);
      wait_hs(1'b1, n);
      wait_hs(1'b0, n);
      wait_hs(1'b1, n);
      wait_hs(1'b0, hi);
      wait_hs(1'b1, lo);
      check("hsync width", hi[15:0], {12'h0, widths[i]});
      check("line length", hi[15:0] + lo[15:0], 16'h0028);
    end
    // skew only shifts the flags, so whole-frame sums stay fixed
    repeat (320) @(negedge clk);
    count_frame(act_n, sp_n, vs_n, cur_n);
    check("shown chars crt", act_n[15:0], 16'h0040);
    check("shift pulse crt", sp_n[15:0], 16'h0000);
    check("vsync clocks", vs_n[15:0], 16'h0028);
    check("cursor chars crt", cur_n[15:0], 16'h0002);
    // lcd keeps an 8-character retrace
    lcd_mode = 1'b1;
    wr(5'h06, 8'hff);
    wr(5'h12, 8'h82);
    wr(5'h13, 8'h15);
    repeat (320) @(negedge clk);
    count_frame(act_n, sp_n, vs_n, cur_n);
    check("shown chars lcd", act_n[15:0], 16'h0080);
    check("shift pulse lcd", sp_n[15:0], 16'h00a0);
    check("cursor chars lcd", cur_n[15:0], 16'h0002);
    check("upper panel cursor", {15'h0, lower_panel}, 16'h0000);
    repeat (3)
    begin
      @(negedge clk);
      pen_capture_strobe = ~pen_capture_strobe;
      pen_seen = refresh_addr;
    end
    rd(5'h10, pen_seen[15:8]);
    rd(5'h11, pen_seen[7:0]);
    repeat (4) @(negedge clk);
    n = expq.size();
    check("pending reads", n[15:0], 16'h0000);
    print_verdict();
  end
endmodule : crtc_lcd_timing_register_set_bench
